/* File: core/acl_action_defs.svh */
// Register indices, field positions, reset values and timing for the ACL action staging block.
// Assumes inclusion by bare name from files that use the macros.
`ifndef ACL_ACTION_DEFS_SVH
`define ACL_ACTION_DEFS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define ACL_IDX_PRIORITY     12'h60A
`define ACL_IDX_REMARK_MAP   12'h60B
`define ACL_IDX_SPARE        12'h60C
`define ACL_IDX_FORWARD      12'h60D
`define ACL_IDX_RULESET_HI   12'h60E
`define ACL_IDX_RULESET_LO   12'h60F
`define ACL_IDX_SEL_HIGH     12'h610
`define ACL_IDX_SEL_LOW      12'h611
`define ACL_IDX_CONTROL      12'h612

// ----------------------------------------
// Slot codes returned by the decoder
// ----------------------------------------
`define ACL_SLOT_SEL_HIGH    4'h6
`define ACL_SLOT_SEL_LOW     4'h7
`define ACL_SLOT_CONTROL     4'h8
`define ACL_SLOT_NONE        4'hF

// ----------------------------------------
// Staging byte numbering
// ----------------------------------------
`define ACL_STAGE_FIRST      4'hA
`define ACL_STAGE_COUNT      6
`define ACL_HIGH_SEL_LAST    4'h7
`define ACL_LOW_SEL_LAST     4'hF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACL_PM_RANGE         7:6
`define ACL_PRIO_RANGE       5:3
`define ACL_RPE_BIT          2
`define ACL_RP_HI_RANGE      1:0
`define ACL_RP_LO_BIT        7
`define ACL_MM_RANGE         6:5
`define ACL_FWD_RANGE        6:0
`define ACL_CTL_WDONE_BIT    6
`define ACL_CTL_RDONE_BIT    5
`define ACL_CTL_DIR_BIT      4
`define ACL_CTL_INDEX_RANGE  3:0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACL_BYTE_RESET       8'h00
`define ACL_WORD_RESET       32'h0000_0000
`define ACL_INDEX_RESET      4'h0
`define ACL_DONE_RESET       1'b1

// ----------------------------------------
// Timing
// ----------------------------------------
`define ACL_CLK_NS           50
`define ACL_XFER_NS          200

`endif

/* File: core/acl_action_pkg.sv */
// Types shared by the ACL action staging block.
// Assumes nothing beyond a SystemVerilog compiler.
package acl_action_pkg;

  // ----------------------------------------
  // Transfer sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_MEM  = 2'b10,
    ST_LOAD = 2'b11
  } xfer_state_t;

endpackage

/* File: core/acl_action_table.sv */
// Per-port ACL table storage for the action bytes, with per-byte write enables.
// Assumes one clock; the read port registers the addressed entry every cycle.
`timescale 1ns/1ps
`default_nettype none

module acl_action_table #(
  parameter int ENTRIES = 16,
  parameter int BYTES   = 6,
  parameter int IDX_W   = 4
) (
  input  wire logic                 clk,
  input  wire logic [BYTES-1:0]     byte_we,
  input  wire logic [IDX_W-1:0]     addr,
  input  wire logic [8*BYTES-1:0]   wdata,
  output logic      [8*BYTES-1:0]   rdata_q
);

  // ----------------------------------------
  // Byte-masked write, registered read
  // ----------------------------------------
  // No reset on the array: table contents are undefined until written, as in RAM
  // One array per byte lane, so each lane has a single writing process
  genvar g;
  generate
    for (g = 0; g < BYTES; g++) begin : g_lane
      logic [7:0] lane [ENTRIES];
      always_ff @(posedge clk) begin
        if (byte_we[g]) begin
          lane[addr] <= wdata[8*g +: 8];
        end
        rdata_q[8*g +: 8] <= lane[addr];
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* File: core/acl_action_access.sv */
// APB register bank staging the action part of a per-port ACL entry, plus table sequencer.
// Assumes an APB master on pclk, asynchronous active-low presetn, one port instance.
`timescale 1ns/1ps
`default_nettype none

`include "acl_action_defs.svh"

// How it works
// - Remark priority upper two bits live in bits 1:0 of the priority register.
// - Remark priority low bit sits at bit 7, map mode at 6:5, remark map register.
// - Priority mode 7:6, priority 5:3, remark enable bit 2; all reset zero.
// - Seven-bit forward map in bits 6:0, bit 0 is port 1, reset zero.
// - Writing the low select register while the sequencer is idle launches a table transfer with current selects.
// - High select bit 0 picks staging byte 7, bit 7 picks byte 0.
// - Low select bit 0 picks staging byte F, bit 7 picks byte 8.
// - Only selected bytes take part in a transfer; both selects reset zero.
// - Read-done clears during a table read; software polls until set.
// - Write-done is one idle, zero during a table write, set when done.
module acl_action_access #(
  parameter int ADDR_W      = 14,
  parameter int ENTRIES     = 16,
  parameter int XFER_CYCLES = (`ACL_XFER_NS + `ACL_CLK_NS - 1) / `ACL_CLK_NS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  output logic      [1:0]        priority_mode_field,
  output logic      [2:0]        priority_value,
  output logic                   remark_priority_enable,
  output logic      [2:0]        remark_priority,
  output logic      [1:0]        map_mode_field,
  output logic      [6:0]        forward_port_map,
  output logic      [15:0]       ruleset,
  output logic                   write_done,
  output logic                   read_done
);

  localparam int NB = `ACL_STAGE_COUNT;

  // ----------------------------------------
  // Decoding and byte selection
  // ----------------------------------------
  function automatic logic [3:0] reg_slot(input logic [ADDR_W-1:0] a);
    logic [11:0] idx;
    idx = 12'(a[ADDR_W-1:2]);
    if (a[1:0] != 2'b00) begin
      return `ACL_SLOT_NONE;
    end
    if (idx >= `ACL_IDX_PRIORITY && idx <= `ACL_IDX_RULESET_LO) begin
      return 4'(idx - `ACL_IDX_PRIORITY);
    end
    case (idx)
      `ACL_IDX_SEL_HIGH: return `ACL_SLOT_SEL_HIGH;
      `ACL_IDX_SEL_LOW:  return `ACL_SLOT_SEL_LOW;
      `ACL_IDX_CONTROL:  return `ACL_SLOT_CONTROL;
      default:           return `ACL_SLOT_NONE;
    endcase
  endfunction

  // Staging byte number b (0..F) to its select bit, in descending order
  function automatic logic byte_selected(input logic [7:0] sel_hi, input logic [7:0] sel_lo,
                                         input logic [3:0] b);
    if (b <= `ACL_HIGH_SEL_LAST) begin
      return sel_hi[3'(`ACL_HIGH_SEL_LAST - b)];
    end
    return sel_lo[3'(`ACL_LOW_SEL_LAST - b)];
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  acl_action_pkg::xfer_state_t state_q, state_d;

  logic [7:0]    stage_q [NB];
  logic [7:0]    stage_d [NB];
  logic [7:0]    sel_hi_q, sel_hi_d;
  logic [7:0]    sel_lo_q, sel_lo_d;
  logic          dir_q, dir_d;
  logic [3:0]    index_q, index_d;
  logic          wdone_q, wdone_d;
  logic          rdone_q, rdone_d;
  logic [NB-1:0] en_q, en_d;
  logic          xdir_q, xdir_d;
  logic [3:0]    xidx_q, xidx_d;
  logic [7:0]    cnt_q, cnt_d;
  logic          pready_q, pready_d;
  logic [31:0]   prdata_q, prdata_d;
  logic          pslverr_q, pslverr_d;

  logic [NB-1:0]   mem_we;
  logic [8*NB-1:0] mem_wdata;
  logic [8*NB-1:0] mem_rdata;
  logic [NB-1:0]   launch_en;
  logic [3:0]      slot;
  logic            take;
  logic            wr;
  logic            launch;

  // ----------------------------------------
  // Table storage
  // ----------------------------------------
  acl_action_table #(
    .ENTRIES (ENTRIES),
    .BYTES   (NB),
    .IDX_W   (4)
  ) u_table (
    .clk     (pclk),
    .byte_we (mem_we),
    .addr    (xidx_q),
    .wdata   (mem_wdata),
    .rdata_q (mem_rdata)
  );

  // Launch enables are taken from the held high select and the low value being written
  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_stage
      assign launch_en[g] = byte_selected(sel_hi_q, pwdata[7:0], 4'(`ACL_STAGE_FIRST + g));
      assign mem_wdata[8*g +: 8] = stage_q[g];
    end
  endgenerate

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state: pready rises at the end of the first access cycle, the write lands on the next edge
  always_comb begin
    slot      = reg_slot(paddr);
    take      = psel & penable & pready_q;
    wr        = take & pwrite & (slot != `ACL_SLOT_NONE);
    launch    = wr & (slot == `ACL_SLOT_SEL_LOW) & (state_q == acl_action_pkg::ST_IDLE);
    pready_d  = psel & penable & ~pready_q;
    pslverr_d = pready_d & (slot == `ACL_SLOT_NONE);
    prdata_d  = `ACL_WORD_RESET;
    if (pready_d) begin
      if (slot < 4'(NB)) begin
        prdata_d = {24'h00_0000, stage_q[3'(slot)]};
      end else if (slot == `ACL_SLOT_SEL_HIGH) begin
        prdata_d = {24'h00_0000, sel_hi_q};
      end else if (slot == `ACL_SLOT_SEL_LOW) begin
        prdata_d = {24'h00_0000, sel_lo_q};
      end else if (slot == `ACL_SLOT_CONTROL) begin
        prdata_d = {24'h00_0000, 1'b0, wdone_q, rdone_q, dir_q, index_q};
      end
    end
  end

  // ----------------------------------------
  // Registers and transfer sequencer
  // ----------------------------------------
  always_comb begin
    state_d  = state_q;
    stage_d  = stage_q;
    sel_hi_d = sel_hi_q;
    sel_lo_d = sel_lo_q;
    dir_d    = dir_q;
    index_d  = index_q;
    wdone_d  = wdone_q;
    rdone_d  = rdone_q;
    en_d     = en_q;
    xdir_d   = xdir_q;
    xidx_d   = xidx_q;
    cnt_d    = cnt_q;
    mem_we   = '0;

    if (wr) begin
      if (slot < 4'(NB)) begin
        stage_d[3'(slot)] = pwdata[7:0];
      end else if (slot == `ACL_SLOT_SEL_HIGH) begin
        sel_hi_d = pwdata[7:0];
      end else if (slot == `ACL_SLOT_SEL_LOW) begin
        sel_lo_d = pwdata[7:0];
      end else if (slot == `ACL_SLOT_CONTROL) begin
        dir_d   = pwdata[`ACL_CTL_DIR_BIT];
        index_d = pwdata[`ACL_CTL_INDEX_RANGE];
      end
    end

    case (state_q)
      acl_action_pkg::ST_IDLE: begin
        if (launch) begin
          en_d    = launch_en;
          xdir_d  = dir_q;
          xidx_d  = index_q;
          cnt_d   = 8'h00;
          state_d = acl_action_pkg::ST_WAIT;
          if (dir_q) begin
            wdone_d = 1'b0;
          end else begin
            rdone_d = 1'b0;
          end
        end
      end
      acl_action_pkg::ST_WAIT: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q >= 8'(XFER_CYCLES - 1)) begin
          state_d = acl_action_pkg::ST_MEM;
        end
      end
      acl_action_pkg::ST_MEM: begin
        if (xdir_q) begin
          mem_we  = en_q;
          wdone_d = 1'b1;
          state_d = acl_action_pkg::ST_IDLE;
        end else begin
          state_d = acl_action_pkg::ST_LOAD;
        end
      end
      acl_action_pkg::ST_LOAD: begin
        for (int k = 0; k < NB; k++) begin
          if (en_q[k]) begin
            stage_d[k] = mem_rdata[8*k +: 8];
          end
        end
        rdone_d = 1'b1;
        state_d = acl_action_pkg::ST_IDLE;
      end
      default: begin
        state_d = acl_action_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= acl_action_pkg::ST_IDLE;
      for (int k = 0; k < NB; k++) begin
        stage_q[k] <= `ACL_BYTE_RESET;
      end
      sel_hi_q  <= `ACL_BYTE_RESET;
      sel_lo_q  <= `ACL_BYTE_RESET;
      dir_q     <= 1'b0;
      index_q   <= `ACL_INDEX_RESET;
      wdone_q   <= `ACL_DONE_RESET;
      rdone_q   <= `ACL_DONE_RESET;
      en_q      <= '0;
      xdir_q    <= 1'b0;
      xidx_q    <= `ACL_INDEX_RESET;
      cnt_q     <= 8'h00;
      pready_q  <= 1'b0;
      prdata_q  <= `ACL_WORD_RESET;
      pslverr_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      stage_q   <= stage_d;
      sel_hi_q  <= sel_hi_d;
      sel_lo_q  <= sel_lo_d;
      dir_q     <= dir_d;
      index_q   <= index_d;
      wdone_q   <= wdone_d;
      rdone_q   <= rdone_d;
      en_q      <= en_d;
      xdir_q    <= xdir_d;
      xidx_q    <= xidx_d;
      cnt_q     <= cnt_d;
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------
  // Staging bytes 0..9 (match fields) live elsewhere; their select bits are held but unused here
  assign pready                 = pready_q;
  assign prdata                 = prdata_q;
  assign pslverr                = pslverr_q;
  assign priority_mode_field    = stage_q[0][`ACL_PM_RANGE];
  assign priority_value         = stage_q[0][`ACL_PRIO_RANGE];
  assign remark_priority_enable = stage_q[0][`ACL_RPE_BIT];
  assign remark_priority        = {stage_q[0][`ACL_RP_HI_RANGE], stage_q[1][`ACL_RP_LO_BIT]};
  assign map_mode_field         = stage_q[1][`ACL_MM_RANGE];
  assign forward_port_map       = stage_q[3][`ACL_FWD_RANGE];
  assign ruleset                = {stage_q[4], stage_q[5]};
  assign write_done             = wdone_q;
  assign read_done              = rdone_q;

endmodule

`default_nettype wire

/* File: sim/acl_action_access_chk.sv */
// Concurrent checks on the ports of the ACL action staging bank.
// Assumes the default transfer length of four cycles; repetition counts follow it.
`timescale 1ns/1ps
`default_nettype none

module acl_action_access_chk #(
  parameter int ADDR_W      = 14,
  parameter int XFER_CYCLES = 4
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic [1:0]        priority_mode_field,
  input wire logic [2:0]        priority_value,
  input wire logic              remark_priority_enable,
  input wire logic [2:0]        remark_priority,
  input wire logic [1:0]        map_mode_field,
  input wire logic [6:0]        forward_port_map,
  input wire logic [15:0]       ruleset,
  input wire logic              write_done,
  input wire logic              read_done
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  // Direction is tracked here because the control register is not a port
  logic acc;
  logic launch;
  logic dir_d;
  logic dir_q;
  assign acc    = psel && penable && pready && pwrite && !pslverr;
  assign launch = acc && paddr == 14'h1844 && write_done && read_done;
  always_comb begin
    dir_d = dir_q;
    if (acc && paddr == 14'h1848) dir_d = pwdata[4];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dir_q <= 1'b0;
    else dir_q <= dir_d;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_busy_w;
    (!write_done)[*5] ##1 write_done;
  endsequence
  sequence s_busy_r;
    (!read_done)[*6] ##1 read_done;
  endsequence

  a_ready_one_wait: assert property (psel && penable && !pready && !$past(penable) |=> pready)
    else $error("pready late or early");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (psel && penable && pready
    && (paddr[1:0] != 2'h0 || paddr < 14'h1828 || paddr > 14'h1848) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_priority_fields: assert property (acc && paddr == 14'h1828 |=>
    {priority_mode_field, priority_value, remark_priority_enable, remark_priority[2:1]}
    == $past(pwdata[7:0])) else $error("priority byte fields wrong");
  a_remark_map_fields: assert property (acc && paddr == 14'h182C |=>
    {remark_priority[0], map_mode_field} == $past(pwdata[7:5])) else $error("remark byte wrong");
  a_forward_map_field: assert property (acc && paddr == 14'h1834 |=>
    forward_port_map == $past(pwdata[6:0])) else $error("forward map wrong");
  a_write_busy_span: assert property (launch && dir_q |=> s_busy_w)
    else $error("write done timing wrong");
  a_read_busy_span: assert property (launch && !dir_q |=> s_busy_r)
    else $error("read done timing wrong");
  a_write_fall_cause: assert property ($fell(write_done) |-> $past(launch && dir_q))
    else $error("write done fell without launch");
endmodule

bind acl_action_access acl_action_access_chk #(.ADDR_W(ADDR_W), .XFER_CYCLES(XFER_CYCLES)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .priority_mode_field(priority_mode_field), .priority_value(priority_value),
  .remark_priority_enable(remark_priority_enable), .remark_priority(remark_priority),
  .map_mode_field(map_mode_field), .forward_port_map(forward_port_map), .ruleset(ruleset),
  .write_done(write_done), .read_done(read_done));
`default_nettype wire

/* File: sim/acl_action_access_bench.sv */
// Self-checking bench for the ACL action staging bank, driven as an APB master.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module acl_action_access_bench;
  typedef struct packed {
    logic [13:0] a;
    logic [7:0]  w;
    logic [7:0]  rst;
    logic [7:0]  rb;
  } row_t;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [13:0] paddr   = 14'h0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, remark_priority_enable, write_done, read_done, er;
  logic [1:0]  priority_mode_field, map_mode_field;
  logic [2:0]  priority_value, remark_priority;
  logic [6:0]  forward_port_map;
  logic [15:0] ruleset;
  logic [33:0] fields;
  int          num_errors = 0;
  int          compares   = 0;
  int          cycles     = 0;
  row_t        rows [9];
  assign fields = {priority_mode_field, priority_value, remark_priority_enable,
                   remark_priority, map_mode_field, forward_port_map, ruleset};

  acl_action_access dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .priority_mode_field(priority_mode_field), .priority_value(priority_value),
    .remark_priority_enable(remark_priority_enable), .remark_priority(remark_priority),
    .map_mode_field(map_mode_field), .forward_port_map(forward_port_map), .ruleset(ruleset),
    .write_done(write_done), .read_done(read_done));

  // ----------------------------------------
  // Clock, timeout, tasks
  // ----------------------------------------
  always #25 pclk = ~pclk;
  // Whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stage(input logic [47:0] v);
    for (int i = 0; i < 6; i++) apb(1'b1, 14'h1828 + 14'(4 * i), v[47 - 8 * i -: 8]);
  endtask
  task automatic stage_chk(input logic [47:0] v);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 14'h1828 + 14'(4 * i), 8'h00);
      chk(rd, {24'h000000, v[47 - 8 * i -: 8]});
    end
    chk(fields, {v[47:37], v[22:0]});
  endtask
  // Done flags are watched for a fixed span longer than the five-cycle write and six-cycle read busy spans
  task automatic xfer(input logic dir, input logic [3:0] idx, input logic [7:0] sel);
    logic seen;
    seen = 1'b0;
    apb(1'b1, 14'h1848, {3'h0, dir, idx});
    apb(1'b1, 14'h1844, sel);
    repeat (12) begin
      @(posedge pclk);
      #1;
      if ((dir ? write_done : read_done) === 1'b0) seen = 1'b1;
    end
    chk(seen, 1'b1);
    chk({write_done, read_done}, 2'h3);
    apb(1'b0, 14'h1848, 8'h00);
    chk(rd, {24'h000000, 3'b011, dir, idx});
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    rows = '{'{14'h1828, 8'hDB, 8'h00, 8'hDB}, '{14'h182C, 8'hE5, 8'h00, 8'hE5},
             '{14'h1830, 8'h3C, 8'h00, 8'h3C}, '{14'h1834, 8'hAA, 8'h00, 8'hAA},
             '{14'h1838, 8'h5A, 8'h00, 8'h5A}, '{14'h183C, 8'hC3, 8'h00, 8'hC3},
             '{14'h1840, 8'h81, 8'h00, 8'h81}, '{14'h1844, 8'h00, 8'h00, 8'h00},
             '{14'h1848, 8'h9A, 8'h60, 8'h7A}};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, rows[i].a, 8'h00);
      chk(rd, {24'h000000, rows[i].rst});
    end
    // Low select is left out here since writing it launches a transfer
    for (int i = 0; i < 9; i++) begin
      if (i != 7) begin
        apb(1'b1, rows[i].a, rows[i].w);
        apb(1'b0, rows[i].a, 8'h00);
        chk(rd, {24'h000000, rows[i].rb});
      end
    end
    stage_chk(48'hDBE53CAA5AC3);
    apb(1'b1, 14'h1829, 8'hFF);
    chk(er, 1'b1);
    apb(1'b0, 14'h1824, 8'h00);
    chk({er, rd}, {1'b1, 32'h0000_0000});
    apb(1'b1, 14'h184C, 8'hFF);
    chk(er, 1'b1);
    stage_chk(48'hDBE53CAA5AC3);
    stage(48'h479E116DBE72);
    xfer(1'b1, 4'h3, 8'h3F);
    stage(48'h000000000000);
    xfer(1'b0, 4'h3, 8'h01);
    stage_chk(48'h000000000072);
    xfer(1'b0, 4'h3, 8'h20);
    stage_chk(48'h470000000072);
    apb(1'b1, 14'h1840, 8'hFF);
    xfer(1'b0, 4'h3, 8'hC0);
    stage_chk(48'h470000000072);
    stage(48'h000000550000);
    xfer(1'b1, 4'h3, 8'h04);
    stage(48'h000000000000);
    xfer(1'b0, 4'h3, 8'h3F);
    stage_chk(48'h479E1155BE72);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk({fields, write_done, read_done}, {34'h0, 2'h3});
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 14'h1840, 8'h00);
    chk(rd, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
